//--- verilog/sep_params.svh
// Purpose: named constants of the three-wire serial eeprom port
// Assumes: included by bare name from the design files
// Notes: times are in their own unit, cycle counts derive from the clock rate
`ifndef SEP_PARAMS_SVH
`define SEP_PARAMS_SVH

// array shape, 1K part
`define SEP_WORDS 64
`define SEP_WIDX_W 6
`define SEP_ERASED 16'hFFFF

// field lengths in shift-clock bits
`define SEP_OPLEN 5'h02
`define SEP_ALEN_X8 5'h07
`define SEP_ALEN_X16 5'h06
`define SEP_DLEN_X8 5'h08
`define SEP_DLEN_X16 5'h10

// opcodes and extended codes
`define SEP_OP_EXT 2'b00
`define SEP_OP_WRITE 2'b01
`define SEP_OP_READ 2'b10
`define SEP_OP_ERASE 2'b11
`define SEP_EXT_DIS 2'b00
`define SEP_EXT_WRITE_ALL_CMD 2'b01
`define SEP_EXT_ERASE_ALL_CMD 2'b10
`define SEP_EXT_EN 2'b11

// self-timed programming cycle
`define SEP_TWP_MS 10
`define SEP_CLK_MHZ 125
`define SEP_TWP_CYCLES (`SEP_TWP_MS * 1000 * `SEP_CLK_MHZ)
`define SEP_TIMER_W 21

`endif

//--- verilog/sep_pkg.sv
// Purpose: types shared by the serial eeprom port
// Assumes: nothing
// Notes: the request struct is the word passed from the link domain
package sep_pkg;

	typedef enum logic [2:0]
	{
		SEP_CMD_NONE = 3'b000,
		SEP_CMD_READ = 3'b001,
		SEP_CMD_EN = 3'b010,
		SEP_CMD_DIS = 3'b011,
		SEP_CMD_ERASE = 3'b100,
		SEP_CMD_WRITE = 3'b101,
		SEP_CMD_ERASE_ALL_CMD = 3'b110,
		SEP_CMD_WRITE_ALL_CMD = 3'b111
	} sep_cmd_t;

	typedef enum logic [2:0]
	{
		SEP_ST_START = 3'b000,
		SEP_ST_OP = 3'b001,
		SEP_ST_ADDR = 3'b010,
		SEP_ST_DATA = 3'b011,
		SEP_ST_READ = 3'b100,
		SEP_ST_DONE = 3'b101
	} sep_state_t;

	typedef struct packed
	{
		sep_cmd_t cmd;
		logic [6:0] addr;
		logic [15:0] data;
	} sep_req_t;

endpackage

//--- verilog/sep_sync.sv
// Purpose: two-flop level synchroniser, any width
// Assumes: each bit is an independent level or a toggle
// Notes: reset value is a parameter so a strap can default high
`timescale 1ns/1ps
module sep_sync
#(
	parameter int W = 1,
	parameter logic [W-1:0] RV = '0
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta;

	// first stage feeds only the second
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta <= RV;
			q <= RV;
		end
		else
		begin
			meta <= d;
			q <= meta;
		end
	end

endmodule // sep_sync

//--- verilog/sep_eeprom_port.sv
// Purpose: device side of a three-wire serial eeprom, 128x8 or 64x16
// Assumes: shift clock is the host's, slow against CLK (>= 500 ns period)
// Notes: link logic runs on SHIFT_CLOCK, array and timer on CLK
`timescale 1ns/1ps
`include "sep_params.svh"

// Summary of operation
// - respond only while chip select high
// - width select high 64x16, low 128x8
// - width select defaults to 16-bit organisation
// - read is opcode 10 plus address
// - read word shifted out one bit per clock
// - write self-timed, overwrites with no erase
// - programming cycle finishes within 10 ms
// - write-type commands ignored unless enabled
// - busy status on output when select rises
// - enable is 00 with address starting 11
// - erase is 11, clears one location
// - write is 01, address, data msb first
// - erase all is 00 with 10 prefix
// - write all is 00, 01 prefix, data
// - disable is 00 with 00 prefix
// - instruction opens with a start bit one
// - dummy zero precedes read data word
// - disabled at power-up, enable sticks
// - status low while busy, high when ready
module sep_eeprom_port
	import sep_pkg::*;
#(
	parameter int PROG_CYCLES = `SEP_TWP_CYCLES
)
(
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic SHIFT_CLOCK,
	input wire logic CHIP_SELECT,
	input wire logic SERIAL_DATA_IN,
	input wire logic WORD_WIDTH_SELECT,
	output logic DATA_OUT,
	output logic DATA_OUT_OE
);

	////////////////////////////////////////////////////////////////////////
	// shared functions

	// word index of an address in either organisation
	function automatic logic [5:0] word_index(input logic [6:0] a, input logic x16);
		word_index = x16 ? a[5:0] : a[6:1];
	endfunction

	// instruction from opcode and leading address bits
	function automatic sep_cmd_t decode_cmd(input logic [1:0] opc, input logic [1:0] ext);
		sep_cmd_t c;
		c = SEP_CMD_NONE;
		case (opc)
			`SEP_OP_READ: c = SEP_CMD_READ;
			`SEP_OP_WRITE: c = SEP_CMD_WRITE;
			`SEP_OP_ERASE: c = SEP_CMD_ERASE;
			default:
			begin
				case (ext)
					`SEP_EXT_EN: c = SEP_CMD_EN;
					`SEP_EXT_DIS: c = SEP_CMD_DIS;
					`SEP_EXT_ERASE_ALL_CMD: c = SEP_CMD_ERASE_ALL_CMD;
					default: c = SEP_CMD_WRITE_ALL_CMD;
				endcase
			end
		endcase
		return c;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// link domain: shift clock

	sep_state_t state, next_state;
	logic [4:0] cnt, next_cnt;
	logic [15:0] sh, shin, osh, next_osh;
	logic [1:0] op, next_op;
	sep_cmd_t cmd_q, next_cmd_q, cmd_now;
	logic [6:0] addr_q, next_addr_q, addr_word;
	logic do_bit, next_do_bit, rd_active, next_rd_active;
	logic frame_rst_n, org_sk;
	logic [4:0] alen, dlen;
	logic [1:0] ext_code;
	logic [15:0] data_word;
	logic addr_done, data_done, issue, req_tgl;
	sep_req_t req, issue_req;
	logic [15:0] rd_word;

	// frame ends the moment chip select drops
	assign frame_rst_n = RSTN & CHIP_SELECT;

	// width strap into the link domain, defaults to x16
	sep_sync #(.W(1), .RV(1'b1)) u_org_sk
	(
		.clk(SHIFT_CLOCK),
		.rst_n(RSTN),
		.d(WORD_WIDTH_SELECT),
		.q(org_sk)
	);

	// field lengths and decoding per organisation
	assign alen = org_sk ? `SEP_ALEN_X16 : `SEP_ALEN_X8;
	assign dlen = org_sk ? `SEP_DLEN_X16 : `SEP_DLEN_X8;
	assign shin = {sh[14:0], SERIAL_DATA_IN};
	assign addr_done = (state == SEP_ST_ADDR) && (cnt == alen - 5'h01);
	assign data_done = (state == SEP_ST_DATA) && (cnt == dlen - 5'h01);
	assign addr_word = org_sk ? {1'b0, shin[5:0]} : shin[6:0];
	assign ext_code = org_sk ? shin[5:4] : shin[6:5];
	assign data_word = org_sk ? shin : {8'h00, shin[7:0]};
	assign cmd_now = decode_cmd(op, ext_code);

	// commands and read addresses handed to the array side
	assign issue = data_done || (addr_done && (cmd_now == SEP_CMD_EN
		|| cmd_now == SEP_CMD_READ
		|| cmd_now == SEP_CMD_DIS || cmd_now == SEP_CMD_ERASE
		|| cmd_now == SEP_CMD_ERASE_ALL_CMD));
	assign issue_req.cmd = data_done ? cmd_q : cmd_now;
	assign issue_req.addr = data_done ? addr_q : addr_word;
	assign issue_req.data = data_done ? data_word : `SEP_ERASED;

	// instruction sequencer
	always_comb
	begin
		next_state = state;
		next_cnt = cnt + 5'h01;
		next_op = op;
		next_cmd_q = cmd_q;
		next_addr_q = addr_q;
		next_do_bit = do_bit;
		next_rd_active = rd_active;
		next_osh = osh;
		case (state)
			SEP_ST_START:
			begin
				next_cnt = 5'h00;
				if (SERIAL_DATA_IN)
					next_state = SEP_ST_OP;
			end
			SEP_ST_OP:
			begin
				if (cnt == `SEP_OPLEN - 5'h01)
				begin
					next_op = shin[1:0];
					next_cnt = 5'h00;
					next_state = SEP_ST_ADDR;
				end
			end
			SEP_ST_ADDR:
			begin
				if (addr_done)
				begin
					next_cnt = 5'h00;
					next_cmd_q = cmd_now;
					next_addr_q = addr_word;
					if (cmd_now == SEP_CMD_READ)
					begin
						next_state = SEP_ST_READ;
						next_do_bit = 1'b0;
						next_rd_active = 1'b1;
					end
					else if (cmd_now == SEP_CMD_WRITE || cmd_now == SEP_CMD_WRITE_ALL_CMD)
						next_state = SEP_ST_DATA;
					else
						next_state = SEP_ST_DONE;
				end
			end
			SEP_ST_DATA:
			begin
				if (data_done)
					next_state = SEP_ST_DONE;
			end
			SEP_ST_READ:
			begin
				next_osh = {osh[14:0], 1'b0};
				next_do_bit = osh[15];
				if (cnt == 5'h00)
				begin
					next_osh = {rd_word[14:0], 1'b0};
					next_do_bit = rd_word[15];
				end
				if (cnt == dlen)
				begin
					next_do_bit = 1'b0;
					next_state = SEP_ST_DONE;
				end
			end
			SEP_ST_DONE: next_cnt = cnt;
			default: next_state = SEP_ST_START;
		endcase
	end

	// frame registers, cleared whenever deselected
	always_ff @(posedge SHIFT_CLOCK or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
		begin
			state <= SEP_ST_START;
			cnt <= 5'h00;
			sh <= 16'h0000;
			osh <= 16'h0000;
			op <= 2'b00;
			cmd_q <= SEP_CMD_NONE;
			addr_q <= 7'h00;
			do_bit <= 1'b0;
			rd_active <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			sh <= shin;
			osh <= next_osh;
			op <= next_op;
			cmd_q <= next_cmd_q;
			addr_q <= next_addr_q;
			do_bit <= next_do_bit;
			rd_active <= next_rd_active;
		end
	end

	// request word and toggle survive deselect
	always_ff @(posedge SHIFT_CLOCK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			req <= '0;
			req_tgl <= 1'b0;
		end
		else
		begin
			if (issue)
			begin
				req <= issue_req;
				req_tgl <= ~req_tgl;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// array domain: CLK

	logic [4:0] sync_in, sync_out;
	logic org_c, cs_c, tgl_c, do_c, rd_c, tgl_d, cs_d;
	logic cmd_evt, start_prog, all_op, wr_en, status_mode;
	logic prog_en, busy;
	logic [`SEP_TIMER_W-1:0] timer;
	logic [6:0] walk;
	sep_req_t preq;
	logic [15:0] wr_val, rd_raw;
	logic [1:0] lane_en;
	logic [7:0] rd_byte;

	// pins and link-domain levels into CLK
	assign sync_in = {WORD_WIDTH_SELECT, CHIP_SELECT, req_tgl, do_bit, rd_active};
	sep_sync #(.W(5), .RV(5'h10)) u_sync_clk
	(
		.clk(CLK),
		.rst_n(RSTN),
		.d(sync_in),
		.q(sync_out)
	);
	assign {org_c, cs_c, tgl_c, do_c, rd_c} = sync_out;

	// command arrival and programming start
	assign cmd_evt = tgl_c ^ tgl_d;
	assign start_prog = cmd_evt && prog_en && !busy
		&& (req.cmd == SEP_CMD_ERASE || req.cmd == SEP_CMD_WRITE
		|| req.cmd == SEP_CMD_ERASE_ALL_CMD || req.cmd == SEP_CMD_WRITE_ALL_CMD);

	// write port: walk covers every word, all-ops hit each
	assign all_op = (preq.cmd == SEP_CMD_ERASE_ALL_CMD) || (preq.cmd == SEP_CMD_WRITE_ALL_CMD);
	assign wr_en = busy && !walk[6]
		&& (all_op || walk[5:0] == word_index(preq.addr, org_c));
	assign wr_val = org_c ? preq.data : {preq.data[7:0], preq.data[7:0]};
	assign lane_en[1] = org_c || all_op || !preq.addr[0];
	assign lane_en[0] = org_c || all_op || preq.addr[0];

	// two byte lanes of storage
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : g_lane
			logic [7:0] lane_mem [0:`SEP_WORDS-1];
			always_ff @(posedge CLK)
			begin
				if (wr_en && lane_en[g])
					lane_mem[walk[5:0]] <= wr_val[g*8 +: 8];
			end
			assign rd_raw[g*8 +: 8] = lane_mem[word_index(req.addr, org_c)];
		end
	endgenerate
	assign rd_byte = req.addr[0] ? rd_raw[7:0] : rd_raw[15:8];

	// edge memory, read word and enable state
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			tgl_d <= 1'b0;
			cs_d <= 1'b0;
			rd_word <= 16'h0000;
			prog_en <= 1'b0;
		end
		else
		begin
			tgl_d <= tgl_c;
			cs_d <= cs_c;
			// read word held still until the next read request
			if (cmd_evt && req.cmd == SEP_CMD_READ)
				rd_word <= org_c ? rd_raw : {rd_byte, 8'h00};
			if (cmd_evt && req.cmd == SEP_CMD_EN)
				prog_en <= 1'b1;
			else if (cmd_evt && req.cmd == SEP_CMD_DIS)
				prog_en <= 1'b0;
		end
	end

	// self-timed programming cycle
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			busy <= 1'b0;
			timer <= '0;
			walk <= 7'h00;
			preq <= '0;
		end
		else if (start_prog)
		begin
			busy <= 1'b1;
			timer <= '0;
			walk <= 7'h00;
			preq <= req;
		end
		else if (busy)
		begin
			timer <= timer + 1'b1;
			if (!walk[6])
				walk <= walk + 7'h01;
			if (timer == `SEP_TIMER_W'(PROG_CYCLES - 1))
				busy <= 1'b0;
		end
	end

	// status mode on each select rise while busy
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
			status_mode <= 1'b0;
		else if (!cs_c)
			status_mode <= 1'b0;
		else if (!cs_d)
			status_mode <= busy;
	end

	// output pin registers
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			DATA_OUT <= 1'b0;
			DATA_OUT_OE <= 1'b0;
		end
		else
		begin
			DATA_OUT <= status_mode ? !busy : do_c;
			DATA_OUT_OE <= cs_c && (status_mode || rd_c);
		end
	end

endmodule // sep_eeprom_port

//--- verification/sep_eeprom_port_assertions.sv
// Purpose: pin checks for the serial eeprom port
// Assumes: host holds select low for at least 4 CLK
// Notes: bound to the design from the bench top
`timescale 1ns/1ps
module sep_eeprom_port_assertions
	import sep_pkg::*;
#(
	parameter int PROG_CYCLES = 100
)
(
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic SHIFT_CLOCK,
	input wire logic CHIP_SELECT,
	input wire logic SERIAL_DATA_IN,
	input wire logic WORD_WIDTH_SELECT,
	input wire logic DATA_OUT,
	input wire logic DATA_OUT_OE
);
	logic [21:0] busy_run;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	sequence oe_on;
		$rose(DATA_OUT_OE);
	endsequence
	sequence desel;
		$fell(CHIP_SELECT);
	endsequence
	////////////////////////////////////////////////////////////////
	// length of a low status stretch with the link clock idle
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
			busy_run <= '0;
		else if (DATA_OUT_OE && !DATA_OUT && !SHIFT_CLOCK)
			busy_run <= busy_run + 22'h1;
		else
			busy_run <= '0;
	end
	////////////////////////////////////////////////////////////////
	AST_OFF_AFTER_DESELECT: assert property (desel |-> ##[1:4] !DATA_OUT_OE)
		else $error("output driven after deselect");
	AST_HOLD_AFTER_DESELECT: assert property (desel ##0 DATA_OUT_OE |=> DATA_OUT_OE)
		else $error("output released too early");
	AST_QUIET_DESELECTED: assert property (!CHIP_SELECT [*4] |=> !$rose(DATA_OUT_OE))
		else $error("output enabled while deselected");
	AST_SELECT_BEFORE_DRIVE: assert property (oe_on |-> $past(CHIP_SELECT, 3))
		else $error("output enabled too soon after select");
	AST_LEAD_BIT_LOW: assert property (oe_on |-> !DATA_OUT)
		else $error("first driven bit not low");
	AST_FALL_ON_LINK_EDGE: assert property ($fell(DATA_OUT) && DATA_OUT_OE
		&& $past(DATA_OUT_OE) && CHIP_SELECT |-> SHIFT_CLOCK)
		else $error("output fell away from a link edge");
	AST_READY_HOLDS: assert property (DATA_OUT && DATA_OUT_OE
		&& CHIP_SELECT && !SHIFT_CLOCK |=> DATA_OUT)
		else $error("ready status dropped");
	AST_BUSY_BOUNDED: assert property (busy_run <= 22'(PROG_CYCLES + 8))
		else $error("busy status too long");
endmodule // sep_eeprom_port_assertions

//--- verification/sep_host_model.sv
// Purpose: serial master driving the eeprom port
// Assumes: link period 64 CLK, above the 500 ns minimum
// Notes: link clock stands low outside ticks
`timescale 1ns/1ps
module sep_host_model
	import sep_pkg::*;
(
	input wire logic clk,
	input wire logic do_pin,
	output logic sk,
	output logic cs,
	output logic di
);
	localparam int HALF = 32;
	// idle levels
	initial
	begin
		sk = 1'b0;
		cs = 1'b0;
		di = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// one link period, low half first
	task automatic tick();
		repeat (HALF) @(negedge clk);
		sk = 1'b1;
		repeat (HALF) @(negedge clk);
		sk = 1'b0;
	endtask
	// one selected frame, msb first, then nrd output bits
	task automatic frame(input logic [31:0] bits, input int n, input int nrd,
		output logic [16:0] rd);
		rd = '0;
		cs = 1'b1;
		for (int i = n - 1; i >= 0; i--)
		begin
			di = bits[i];
			tick();
		end
		for (int i = 0; i < nrd; i++)
		begin
			rd = {rd[15:0], do_pin};
			if (i < nrd - 1)
				tick();
		end
		repeat (HALF) @(negedge clk);
		cs = 1'b0;
		repeat (8) @(negedge clk);
	endtask
	// status poll with a bounded wait for ready
	task automatic poll(output logic first, output int wn);
		cs = 1'b1;
		repeat (6) @(negedge clk);
		first = do_pin;
		wn = 0;
		while (do_pin !== 1'b1 && wn < 400)
		begin
			@(negedge clk);
			wn++;
		end
		cs = 1'b0;
		repeat (8) @(negedge clk);
	endtask
endmodule // sep_host_model

//--- verification/sep_eeprom_port_tb.sv
// Purpose: self-checking bench for the serial eeprom port
// Assumes: short programming cycle through PROG_CYCLES
// Notes: array model is 64 words of 16 bits
`timescale 1ns/1ps
module sep_eeprom_port_tb
	import sep_pkg::*;
;
	localparam int PROG_CYCLES = 100;
	logic CLK = 1'b0;
	logic RSTN = 1'b0;
	logic org_drv = 1'bz;
	logic en = 1'b0;
	logic [15:0] e;
	logic [15:0] mem [64];
	int n_errors = 0;
	int checks_done = 0;
	tri1 org_pin;
	wire sk;
	wire cs;
	wire di;
	wire dout;
	wire oe;
	wire do_pin;
	// pad pull-up on the strap, pin level from the enable
	assign org_pin = org_drv;
	assign do_pin = oe ? dout : 1'bz;
	always #4 CLK = ~CLK;
	sep_eeprom_port #(.PROG_CYCLES(PROG_CYCLES)) sep_eeprom_port_i
	(
		.CLK(CLK),
		.RSTN(RSTN),
		.SHIFT_CLOCK(sk),
		.CHIP_SELECT(cs),
		.SERIAL_DATA_IN(di),
		.WORD_WIDTH_SELECT(org_pin),
		.DATA_OUT(dout),
		.DATA_OUT_OE(oe)
	);
	sep_host_model sep_host_model_i
	(
		.clk(CLK),
		.do_pin(do_pin),
		.sk(sk),
		.cs(cs),
		.di(di)
	);
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [16:0] seen, input logic [16:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// one instruction on the link, checked against the array model
	task automatic cmd(input logic [1:0] op, input logic [6:0] a, input logic [15:0] d);
		int al;
		int nd;
		int wn;
		logic [31:0] bits;
		logic [16:0] rd;
		logic [5:0] wi;
		logic [1:0] pre;
		logic first;
		logic w;
		w = org_drv !== 1'b0;
		al = w ? 6 : 7;
		wi = w ? a[5:0] : a[6:1];
		pre = w ? a[5:4] : a[6:5];
		nd = (op == 2'b01 || (op == 2'b00 && pre == 2'b01)) ? (w ? 16 : 8) : 0;
		bits = ((({29'h0, 1'b1, op} << al) | 32'(a)) << nd) | 32'(d);
		e = w ? mem[wi] : {8'h00, a[0] ? mem[wi][7:0] : mem[wi][15:8]};
		sep_host_model_i.frame(bits, 3 + al + nd, op == 2'b10 ? (w ? 17 : 9) : 0, rd);
		if (op == 2'b10)
			check(rd, {1'b0, e});
		else if (op != 2'b00 || pre == 2'b01 || pre == 2'b10)
		begin
			sep_host_model_i.poll(first, wn);
			check({16'h0, first}, {16'h0, en ? 1'b0 : 1'bz});
			if (en)
				check(17'(wn > 0 && wn <= PROG_CYCLES), 17'h1);
			if (en && op == 2'b01)
				mem[wi] = w ? d : (a[0] ? {mem[wi][15:8], d[7:0]} : {d[7:0], mem[wi][7:0]});
			if (en && op == 2'b11)
				mem[wi] = w ? 16'hffff : (a[0] ? mem[wi] | 16'h00ff : mem[wi] | 16'hff00);
			if (en && op == 2'b00)
				foreach (mem[i]) mem[i] = pre[1] ? 16'hffff : (w ? d : {d[7:0], d[7:0]});
		end
		else
			en = pre[0];
	endtask
	////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		logic [6:0] a;
		void'($urandom(32'h5fa6));
		repeat (3) @(negedge CLK);
		RSTN = 1'b1;
		repeat (4) @(negedge CLK);
		sep_host_model_i.tick();
		sep_host_model_i.tick();
		cmd(2'b01, 7'h05, 16'h1234);
		cmd(2'b00, 7'h30, 16'h0);
		cmd(2'b00, 7'h20, 16'h0);
		cmd(2'b10, 7'h3f, 16'h0);
		$display("done: enable and erase all");
		repeat (4)
		begin
			a = 7'($urandom_range(63));
			cmd(2'b01, a, 16'($urandom));
			cmd(2'b01, a, 16'($urandom));
			cmd(2'b10, a, 16'h0);
		end
		$display("done: write and overwrite");
		cmd(2'b11, a, 16'h0);
		cmd(2'b10, a, 16'h0);
		cmd(2'b10, a ^ 7'h01, 16'h0);
		cmd(2'b00, 7'h10, 16'($urandom));
		cmd(2'b10, 7'h00, 16'h0);
		cmd(2'b00, 7'h00, 16'h0);
		cmd(2'b11, 7'h00, 16'h0);
		cmd(2'b10, 7'h00, 16'h0);
		$display("done: erase, write all, disable");
		org_drv = 1'b0;
		sep_host_model_i.tick();
		sep_host_model_i.tick();
		cmd(2'b00, 7'h60, 16'h0);
		a = 7'($urandom_range(127));
		cmd(2'b01, a, 16'($urandom_range(255)));
		cmd(2'b10, a, 16'h0);
		cmd(2'b10, a ^ 7'h01, 16'h0);
		$display("done: byte organisation");
		close_out();
	end
	// watchdog
	initial
	begin
		#700000;
		n_errors++;
		$display("MISMATCH %0t watchdog expired", $time);
		close_out();
	end
endmodule // sep_eeprom_port_tb

bind sep_eeprom_port sep_eeprom_port_assertions #(.PROG_CYCLES(PROG_CYCLES)) chk_i
(
	.CLK(CLK),
	.RSTN(RSTN),
	.SHIFT_CLOCK(SHIFT_CLOCK),
	.CHIP_SELECT(CHIP_SELECT),
	.SERIAL_DATA_IN(SERIAL_DATA_IN),
	.WORD_WIDTH_SELECT(WORD_WIDTH_SELECT),
	.DATA_OUT(DATA_OUT),
	.DATA_OUT_OE(DATA_OUT_OE)
);
